// >>> verilog/gph_mode_handler.sv
// module: bus protocol mode handler with talk trigger and apb registers
//
// Behaviour
// - protocol flag: 1 selects message-exchange protocol, 0 selects fast protocol; readable
// - unprogrammed storage gives the message-exchange protocol
// - changing protocol clears only the blinking remote indicator, unless remote enable rises with it; all other state is kept
// - protocol choice is written to storage and reloaded after power-up
// - a protocol change clears the blinking remote indicator unless remote enable rises in the same cycle
// - in fast mode device clear or interface clear abandons a pending query
// - in fast mode talk before terminator jams input parser until a clear
// - partly read response keeps output task busy until terminator or clear
// - fast mode holds off bus at terminator until commands done or error
// - operation-complete and wait commands still complete in fast mode
// - fast mode talk without query triggers a read of active channel
// - fast mode sets message-available when query processing completes
// - fast mode formats response at first talk addressing for it
// - go-to-local cancels lockout; local key works unless locked out
// - one response may be read across several talk addressings
// - dual setting returns channel one then channel two; else active channel
// - dual setting accepted always, acts only in fast mode
// - dual setting powers up off; reset clears it
// - dual talk trigger leaves channel two active
`timescale 1ns/1ps
module gph_mode_handler (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // bus pins from the interface front end (asynchronous)
   input wire logic talk_pin,
   input wire logic dcl_pin,
   input wire logic ifc_pin,
   input wire logic gtl_pin,
   input wire logic llo_pin,
   input wire logic local_key_pin,
   input wire logic ren_pin,
   // message parser events (same clock)
   input wire logic query_rx,
   input wire logic line_busy,
   input wire logic term_rx,
   input wire logic cmds_done,
   input wire logic parse_err,
   input wire logic opc_cmd,
   input wire logic query_done,
   input wire logic outbuf_nonempty,
   input wire logic resp_term_sent,
   // nonvolatile storage
   input wire logic store_valid,
   input wire logic store_prot,
   output logic store_wr,
   output logic store_wr_data,
   // outputs to instrument
   output logic hold_off,
   output logic mav,
   output logic [1:0] trig_read,
   output logic fmt_req,
   output logic opc_done,
   output logic remote_blink,
   output logic lockout,
   output logic parser_reset
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [gph_pkg::PIN_COUNT-1:0] pin_raw;
   logic [gph_pkg::PIN_COUNT-1:0] sync1_reg;
   logic [gph_pkg::PIN_COUNT-1:0] sync2_reg;
   logic [gph_pkg::PIN_COUNT-1:0] prev_reg;
   logic [gph_pkg::PIN_COUNT-1:0] rise;
   assign pin_raw = {ren_pin, local_key_pin, llo_pin, gtl_pin, ifc_pin, dcl_pin, talk_pin};
   genvar gi;
   generate
      for (gi = 0; gi < gph_pkg::PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
               prev_reg[gi] <= 1'b0;
            end else if (ce) begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               prev_reg[gi] <= sync2_reg[gi];
            end
         end
         assign rise[gi] = sync2_reg[gi] & ~prev_reg[gi];
      end
   endgenerate
   logic talk_rise;
   logic clear_ev;
   logic ren_fall;
   assign talk_rise = rise[gph_pkg::PIN_TALK];
   assign clear_ev = rise[gph_pkg::PIN_DCL] | rise[gph_pkg::PIN_IFC];
   assign ren_fall = ~sync2_reg[gph_pkg::PIN_REN] & prev_reg[gph_pkg::PIN_REN];
   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == gph_pkg::CTRL_OFS) || (a == gph_pkg::STAT_OFS) || (a == gph_pkg::STORE_OFS);
   endfunction
   logic acc;
   logic ctrl_wr;
   assign acc = psel & penable & pready;
   assign ctrl_wr = acc & pwrite & (paddr == gph_pkg::CTRL_OFS);
   // ---------------------------------------------------------------
   // state declarations
   // ---------------------------------------------------------------
   gph_pkg::gph_load_e load_reg;
   logic prot_reg;
   logic dual_reg;
   logic chan_reg;
   logic qpend_reg;
   logic fmt_reg;
   logic obusy_reg;
   logic pstuck_reg;
   logic remote_reg;
   logic opc_pend_reg;
   logic fast;
   logic prot_next;
   logic prot_change;
   logic auto_trig;
   assign fast = (prot_reg == gph_pkg::PROT_FAST);
   assign prot_next = pwdata[gph_pkg::CTRL_PROT_BIT];
   assign prot_change = ctrl_wr & (prot_next != prot_reg);
   // talk with nothing pending and no response in progress
   assign auto_trig = fast & talk_rise & ~qpend_reg & ~obusy_reg & ~mav & ~line_busy & ~pstuck_reg;
   // ---------------------------------------------------------------
   // apb answer
   // ---------------------------------------------------------------
   logic [31:0] stat_word;
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[gph_pkg::ST_HOLD_BIT] = hold_off;
      stat_word[gph_pkg::ST_MAV_BIT] = mav;
      stat_word[gph_pkg::ST_QPEND_BIT] = qpend_reg;
      stat_word[gph_pkg::ST_PSTUCK_BIT] = pstuck_reg;
      stat_word[gph_pkg::ST_OBUSY_BIT] = obusy_reg;
      stat_word[gph_pkg::ST_BLINK_BIT] = remote_blink;
      stat_word[gph_pkg::ST_LOCK_BIT] = lockout;
      stat_word[gph_pkg::ST_FMT_BIT] = fmt_reg;
      stat_word[gph_pkg::ST_REMOTE_BIT] = remote_reg;
      stat_word[gph_pkg::ST_OPC_BIT] = opc_pend_reg;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~is_mapped(paddr);
         prdata <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               gph_pkg::CTRL_OFS: prdata <= {29'h0000_0000, chan_reg, dual_reg, prot_reg};
               gph_pkg::STAT_OFS: prdata <= stat_word;
               gph_pkg::STORE_OFS: prdata <= {30'h0000_0000, store_valid, store_prot};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // protocol select and storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_reg <= gph_pkg::LD_WAIT;
         prot_reg <= gph_pkg::PROT_FACTORY;
         store_wr <= 1'b0;
         store_wr_data <= gph_pkg::PROT_FACTORY;
      end else if (ce) begin
         store_wr <= 1'b0;
         case (load_reg)
            gph_pkg::LD_WAIT: begin
               load_reg <= gph_pkg::LD_DONE;
               prot_reg <= store_valid ? store_prot : gph_pkg::PROT_FACTORY;
            end
            gph_pkg::LD_DONE: begin
               if (prot_change) begin
                  prot_reg <= prot_next;
                  store_wr <= 1'b1;
                  store_wr_data <= prot_next;
               end
            end
            default: load_reg <= gph_pkg::LD_WAIT;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // dual talk setting and active channel
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dual_reg <= gph_pkg::DUAL_RESET;
         chan_reg <= gph_pkg::CHAN_ONE;
      end else if (ce) begin
         if (ctrl_wr) begin
            dual_reg <= pwdata[gph_pkg::CTRL_DUAL_BIT];
            chan_reg <= pwdata[gph_pkg::CTRL_CHAN_BIT];
         end
         if (auto_trig & dual_reg) begin
            chan_reg <= gph_pkg::CHAN_TWO;
         end
      end
   end
   // ---------------------------------------------------------------
   // talk trigger and response formatting
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_read <= gph_pkg::READ_NONE;
         fmt_req <= 1'b0;
         fmt_reg <= 1'b0;
      end else if (ce) begin
         trig_read <= gph_pkg::READ_NONE;
         fmt_req <= 1'b0;
         if (auto_trig) begin
            if (dual_reg) begin
               trig_read <= gph_pkg::READ_DUAL;
            end else begin
               trig_read <= chan_reg ? gph_pkg::READ_TWO : gph_pkg::READ_ONE;
            end
         end
         if (fast & talk_rise & mav & ~fmt_reg) begin
            fmt_req <= 1'b1;
            fmt_reg <= 1'b1;
         end else if (clear_ev | resp_term_sent) begin
            fmt_reg <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // query, message available and output task
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         qpend_reg <= 1'b0;
         mav <= 1'b0;
         obusy_reg <= 1'b0;
      end else if (ce) begin
         if (query_rx | auto_trig) begin
            qpend_reg <= 1'b1;
         end else if (clear_ev | query_done) begin
            qpend_reg <= 1'b0;
         end
         if (fast) begin
            if (query_done & qpend_reg) begin
               mav <= 1'b1;
            end else if (clear_ev | resp_term_sent) begin
               mav <= 1'b0;
            end
         end else begin
            mav <= outbuf_nonempty & ~clear_ev;
         end
         if (talk_rise & (mav | qpend_reg)) begin
            obusy_reg <= 1'b1;
         end else if (clear_ev | resp_term_sent) begin
            obusy_reg <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // input parser jam, hold-off, operation complete
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pstuck_reg <= 1'b0;
         parser_reset <= 1'b0;
         hold_off <= 1'b0;
         opc_pend_reg <= 1'b0;
         opc_done <= 1'b0;
      end else if (ce) begin
         parser_reset <= clear_ev;
         if (fast & talk_rise & line_busy) begin
            pstuck_reg <= 1'b1;
         end else if (clear_ev) begin
            pstuck_reg <= 1'b0;
         end
         if (fast & term_rx) begin
            hold_off <= 1'b1;
         end else if (cmds_done | parse_err) begin
            hold_off <= 1'b0;
         end
         opc_done <= 1'b0;
         if (opc_cmd) begin
            opc_pend_reg <= 1'b1;
         end else if (opc_pend_reg & (cmds_done | parse_err)) begin
            opc_pend_reg <= 1'b0;
            opc_done <= 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // remote, local and lockout
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remote_reg <= 1'b0;
         remote_blink <= 1'b0;
         lockout <= 1'b0;
      end else if (ce) begin
         if (rise[gph_pkg::PIN_LLO]) begin
            lockout <= 1'b1;
         end else if (rise[gph_pkg::PIN_GTL] | ren_fall) begin
            lockout <= 1'b0;
         end
         if (rise[gph_pkg::PIN_REN]) begin
            remote_reg <= 1'b1;
         end else if (ren_fall | (rise[gph_pkg::PIN_GTL] & ~fast)) begin
            remote_reg <= 1'b0;
         end else if (rise[gph_pkg::PIN_LKEY] & ~lockout) begin
            remote_reg <= 1'b0;
         end
         if (rise[gph_pkg::PIN_REN]) begin
            remote_blink <= 1'b1;
         end else if (prot_change | ~remote_reg) begin
            remote_blink <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_term_fast;
      ce & fast & term_rx;
   endsequence
   sequence s_release;
      ce & (cmds_done | parse_err) & ~(fast & term_rx);
   endsequence
   a_prot_store: assert property (ce & prot_change |=> store_wr & (prot_reg == store_wr_data))
      else $error("protocol change not stored");
   a_prot_keep: assert property (ce & ~ctrl_wr & (load_reg == gph_pkg::LD_DONE) |=> $stable(prot_reg))
      else $error("protocol changed without a write");
   a_blink_clear: assert property (ce & prot_change & ~rise[gph_pkg::PIN_REN] |=> ~remote_blink)
      else $error("blink kept after protocol change");
   a_hold_set: assert property (s_term_fast |=> hold_off)
      else $error("hold-off missing after terminator");
   a_hold_rel: assert property (s_release |=> ~hold_off)
      else $error("hold-off not released");
   a_dual_read: assert property (auto_trig & ce & dual_reg |=> trig_read == gph_pkg::READ_DUAL ##0 chan_reg)
      else $error("dual trigger wrong");
   a_single_read: assert property (auto_trig & ce & ~dual_reg & ~ctrl_wr
                                   |=> trig_read == (chan_reg ? gph_pkg::READ_TWO : gph_pkg::READ_ONE))
      else $error("single trigger wrong channel");
   a_no_trig_scpi: assert property (~fast |-> ##1 trig_read == gph_pkg::READ_NONE)
      else $error("talk trigger in exchange protocol");
   a_mav_fast: assert property (ce & fast & query_done & qpend_reg |=> mav)
      else $error("message available not set");
   a_clear_query: assert property (ce & clear_ev & ~query_rx & ~auto_trig |=> ~qpend_reg)
      else $error("pending query survived clear");
   a_gtl_lock: assert property (ce & rise[gph_pkg::PIN_GTL] & ~rise[gph_pkg::PIN_LLO] |=> ~lockout)
      else $error("lockout kept after go-to-local");
endmodule

// >>> verilog/gph_pkg.sv
// package: constants for the bus protocol mode handler
package gph_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] STORE_OFS = 8'h08;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTRL_PROT_BIT = 0;
   localparam int CTRL_DUAL_BIT = 1;
   localparam int CTRL_CHAN_BIT = 2;
   // ---------------------------------------------------------------
   // status register fields
   // ---------------------------------------------------------------
   localparam int ST_HOLD_BIT = 0;
   localparam int ST_MAV_BIT = 1;
   localparam int ST_QPEND_BIT = 2;
   localparam int ST_PSTUCK_BIT = 3;
   localparam int ST_OBUSY_BIT = 4;
   localparam int ST_BLINK_BIT = 5;
   localparam int ST_LOCK_BIT = 6;
   localparam int ST_FMT_BIT = 7;
   localparam int ST_REMOTE_BIT = 8;
   localparam int ST_OPC_BIT = 9;
   // ---------------------------------------------------------------
   // reset values and encodings
   // ---------------------------------------------------------------
   localparam logic PROT_EXCHANGE = 1'b1;
   localparam logic PROT_FAST = 1'b0;
   localparam logic PROT_FACTORY = PROT_EXCHANGE;
   localparam logic DUAL_RESET = 1'b0;
   localparam logic CHAN_ONE = 1'b0;
   localparam logic CHAN_TWO = 1'b1;
   localparam logic [1:0] READ_NONE = 2'h0;
   localparam logic [1:0] READ_ONE = 2'h1;
   localparam logic [1:0] READ_TWO = 2'h2;
   localparam logic [1:0] READ_DUAL = 2'h3;
   // ---------------------------------------------------------------
   // synchronised pin indices
   // ---------------------------------------------------------------
   localparam int PIN_TALK = 0;
   localparam int PIN_DCL = 1;
   localparam int PIN_IFC = 2;
   localparam int PIN_GTL = 3;
   localparam int PIN_LLO = 4;
   localparam int PIN_LKEY = 5;
   localparam int PIN_REN = 6;
   localparam int PIN_COUNT = 7;
   // ---------------------------------------------------------------
   // start-up load state machine
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      LD_WAIT = 1'b0,
      LD_DONE = 1'b1
   } gph_load_e;
endpackage

// >>> verif/gph_ctl_model.sv
// bus controller model: talk, clear, local pins and line events
`timescale 1ns/1ps
module gph_ctl_model (
   // clock
   input wire logic clk,
   // bus pins
   output logic talk_pin,
   output logic dcl_pin,
   output logic ifc_pin,
   output logic gtl_pin,
   output logic llo_pin,
   output logic local_key_pin,
   output logic ren_pin,
   // line events
   output logic line_busy,
   output logic query_rx,
   output logic term_rx
);
   logic [6:0] pins;
   assign talk_pin = pins[gph_pkg::PIN_TALK];
   assign dcl_pin = pins[gph_pkg::PIN_DCL];
   assign ifc_pin = pins[gph_pkg::PIN_IFC];
   assign gtl_pin = pins[gph_pkg::PIN_GTL];
   assign llo_pin = pins[gph_pkg::PIN_LLO];
   assign local_key_pin = pins[gph_pkg::PIN_LKEY];
   assign ren_pin = pins[gph_pkg::PIN_REN];
   initial begin
      pins = 7'h00;
      line_busy = 1'b0;
      query_rx = 1'b0;
      term_rx = 1'b0;
   end
   // pin pulse, 4 cycles high then idle; clears recover query, parser, output
   task automatic pin_pulse(input int idx);
      @(posedge clk) pins[idx] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[idx] <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   task automatic set_ren(input logic v);
      @(posedge clk) pins[gph_pkg::PIN_REN] <= v;
      repeat (5) @(posedge clk);
   endtask
   task automatic open_line(input logic v);
      @(posedge clk) line_busy <= v;
   endtask
   // one line, at most one query placed last, never terminator alone
   task automatic send_line(input logic with_query);
      @(posedge clk) line_busy <= 1'b1;
      @(posedge clk) query_rx <= with_query;
      @(posedge clk) query_rx <= 1'b0;
      term_rx <= 1'b1;
      line_busy <= 1'b0;
      @(posedge clk) term_rx <= 1'b0;
      // settle time before anything further
      repeat (3) @(posedge clk);
   endtask
endmodule

// >>> verif/gph_mode_handler_tb_top.sv
// testbench for the bus protocol mode handler
`timescale 1ns/1ps
module gph_mode_handler_tb_top;
   logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic [4:0] evs = 5'h00;
   logic outbuf_nonempty = 0, store_valid = 0, store_prot = 0, rerr, last_wr;
   logic store_wr, store_wr_data, hold_off, mav, fmt_req, opc_done, remote_blink, lockout, parser_reset;
   logic [1:0] trig_read, last_trig;
   logic talk_pin, dcl_pin, ifc_pin, gtl_pin, llo_pin, local_key_pin, ren_pin, line_busy, query_rx, term_rx;
   int errors = 0, n_compared = 0, n_trig = 0, n_fmt = 0, n_opc = 0, n_wr = 0, cyc = 0;
   localparam int EV_DONE = 0, EV_ERR = 1, EV_OPC = 2, EV_QDONE = 3, EV_TERM = 4;
   always #50 clk = ~clk;
   gph_mode_handler DUT (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .talk_pin(talk_pin), .dcl_pin(dcl_pin), .ifc_pin(ifc_pin), .gtl_pin(gtl_pin), .llo_pin(llo_pin),
      .local_key_pin(local_key_pin), .ren_pin(ren_pin), .query_rx(query_rx), .line_busy(line_busy),
      .term_rx(term_rx), .cmds_done(evs[EV_DONE]), .parse_err(evs[EV_ERR]), .opc_cmd(evs[EV_OPC]),
      .query_done(evs[EV_QDONE]), .outbuf_nonempty(outbuf_nonempty), .resp_term_sent(evs[EV_TERM]),
      .store_valid(store_valid), .store_prot(store_prot), .store_wr(store_wr), .store_wr_data(store_wr_data),
      .hold_off(hold_off), .mav(mav), .trig_read(trig_read), .fmt_req(fmt_req), .opc_done(opc_done),
      .remote_blink(remote_blink), .lockout(lockout), .parser_reset(parser_reset));
   gph_ctl_model ctl (.clk(clk), .talk_pin(talk_pin), .dcl_pin(dcl_pin), .ifc_pin(ifc_pin),
      .gtl_pin(gtl_pin), .llo_pin(llo_pin), .local_key_pin(local_key_pin), .ren_pin(ren_pin),
      .line_busy(line_busy), .query_rx(query_rx), .term_rx(term_rx));
   // ---------------------------------------------------------------
   // output monitors
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (trig_read !== 2'h0) begin
         n_trig++;
         last_trig = trig_read;
      end
      if (fmt_req === 1'b1) n_fmt++;
      if (opc_done === 1'b1) n_opc++;
      if (store_wr === 1'b1) begin
         n_wr++;
         last_wr = store_wr_data;
      end
      if (cyc == 6000) begin
         errors++;
         tally_and_finish();
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ev(input int i);
      @(posedge clk) evs[i] <= 1'b1;
      @(posedge clk) evs[i] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic do_reset();
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic s_factory();
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("prot after reset", rdat[0], 1);
      chk("dual after reset", rdat[1], 0);
      apb(0, 8'h0c, 32'h0000_0000);
      chk("unmapped data", rdat, 0);
      chk("unmapped error", rerr, 1);
      apb(1, gph_pkg::CTRL_OFS, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk("store writes", n_wr, 1);
      chk("stored prot", last_wr, 0);
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("prot readback", rdat, 0);
   endtask
   task automatic s_blink();
      apb(1, gph_pkg::CTRL_OFS, 32'h0000_0006);
      ctl.set_ren(1'b1);
      ctl.pin_pulse(gph_pkg::PIN_LLO);
      chk("blink and lock", {remote_blink, lockout}, 2'b11);
      ctl.pin_pulse(gph_pkg::PIN_LKEY);
      apb(0, gph_pkg::STAT_OFS, 32'h0000_0000);
      chk("key locked out", rdat[gph_pkg::ST_REMOTE_BIT], 1);
      apb(1, gph_pkg::CTRL_OFS, 32'h0000_0007);
      repeat (2) @(posedge clk);
      chk("blink cleared", remote_blink, 0);
      chk("lock kept", lockout, 1);
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("ctrl kept", rdat, 7);
      ctl.pin_pulse(gph_pkg::PIN_GTL);
      chk("gtl unlocks", lockout, 0);
      ctl.set_ren(1'b0);
   endtask
   task automatic s_talk(input logic [2:0] ctrl, input logic [1:0] exp);
      int t, f;
      t = n_trig;
      apb(1, gph_pkg::CTRL_OFS, {29'h0, ctrl});
      ctl.pin_pulse(gph_pkg::PIN_TALK);
      chk("talk trigger", last_trig, exp);
      chk("one trigger", n_trig - t, 1);
      ev(EV_QDONE);
      chk("mav on done", mav, 1);
      f = n_fmt;
      ctl.pin_pulse(gph_pkg::PIN_TALK);
      chk("format on talk", n_fmt - f, 1);
      ctl.pin_pulse(gph_pkg::PIN_TALK);
      chk("second talk format", n_fmt - f, 1);
      chk("second talk trigger", n_trig - t, 1);
      chk("mav held", mav, 1);
      ev(EV_TERM);
      chk("mav cleared", mav, 0);
   endtask
   task automatic s_modes();
      int t;
      s_talk(3'b000, gph_pkg::READ_ONE);
      s_talk(3'b100, gph_pkg::READ_TWO);
      s_talk(3'b010, gph_pkg::READ_DUAL);
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("chan two left", rdat[gph_pkg::CTRL_CHAN_BIT], 1);
      outbuf_nonempty <= 1'b1;
      repeat (4) @(posedge clk);
      chk("no mav from buffer", mav, 0);
      apb(1, gph_pkg::CTRL_OFS, 32'h0000_0003);
      repeat (3) @(posedge clk);
      chk("mav from buffer", mav, 1);
      outbuf_nonempty <= 1'b0;
      repeat (3) @(posedge clk);
      t = n_trig;
      ctl.pin_pulse(gph_pkg::PIN_TALK);
      chk("no trigger exchange", n_trig - t, 0);
      apb(1, gph_pkg::CTRL_OFS, 32'h0000_0000);
   endtask
   task automatic s_hold();
      ce <= 1'b0;
      ctl.send_line(1'b0);
      chk("frozen hold", hold_off, 0);
      ce <= 1'b1;
      ctl.send_line(1'b0);
      chk("hold on term", hold_off, 1);
      ev(EV_OPC);
      ev(EV_DONE);
      chk("hold released", hold_off, 0);
      chk("opc done", n_opc, 1);
      ctl.send_line(1'b0);
      ev(EV_ERR);
      chk("hold error", hold_off, 0);
      ctl.send_line(1'b1);
      apb(0, gph_pkg::STAT_OFS, 32'h0000_0000);
      chk("query pending", rdat[gph_pkg::ST_QPEND_BIT], 1);
      ctl.pin_pulse(gph_pkg::PIN_DCL);
      apb(0, gph_pkg::STAT_OFS, 32'h0000_0000);
      chk("query abandoned", rdat[gph_pkg::ST_QPEND_BIT], 0);
      ctl.open_line(1'b1);
      ctl.pin_pulse(gph_pkg::PIN_TALK);
      ctl.open_line(1'b0);
      apb(0, gph_pkg::STAT_OFS, 32'h0000_0000);
      chk("parser jammed", rdat[gph_pkg::ST_PSTUCK_BIT], 1);
      ctl.pin_pulse(gph_pkg::PIN_IFC);
      apb(0, gph_pkg::STAT_OFS, 32'h0000_0000);
      chk("parser freed", rdat[gph_pkg::ST_PSTUCK_BIT], 0);
   endtask
   task automatic s_power();
      apb(1, gph_pkg::CTRL_OFS, 32'h0000_0003);
      store_valid <= 1'b1;
      store_prot <= 1'b0;
      do_reset();
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("stored prot loaded", rdat, 0);
      apb(0, gph_pkg::STORE_OFS, 32'h0000_0000);
      chk("store view", rdat, 2);
      store_prot <= 1'b1;
      do_reset();
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("stored one loaded", rdat, 1);
      store_valid <= 1'b0;
      store_prot <= 1'b0;
      do_reset();
      apb(0, gph_pkg::CTRL_OFS, 32'h0000_0000);
      chk("blank store factory", rdat, 1);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      s_factory();
      s_blink();
      s_modes();
      s_hold();
      s_power();
      tally_and_finish();
   end
endmodule
